// *** src/bl_reg_bank.sv ***
// step-down and linear regulator setting registers behind an i2c target
`timescale 1ns/1ps
`default_nettype none
// Contract
// - power-up slot is a read-only 3-bit code: disabled, 0%, 25%, 50%, reserved.
// - peak current code maps to 50 mA per step, 50 mA up to 400 mA.
// - inductor select clear means 2.2 uH, set means 4.7 uH.
// - linear regulator code zero gives 0.9 V, each step adds 0.1 V.
// - linear regulator code 10000 gives 2.5 V, 11111 gives 4.0 V.
module bl_reg_bank (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // i2c pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  // strap and regulator status
  input  wire logic [2:0] seq_strap_i,
  input  wire logic       buck_enabled_i,
  // step-down controls
  output logic [5:0]      buck_vcode_o,
  output logic [1:0]      buck_enable_sel_o,
  output logic [1:0]      buck_mode_sel_o,
  output logic            buck_fast_start_o,
  output logic [8:0]      buck_ipk_ma_o,
  output logic            buck_cmp_fpwm_o,
  output logic            buck_ind_4u7_o,
  output logic            buck_hys_off_o,
  output logic            buck_min_ot_o,
  output logic            buck_integ_o,
  // power-up slot decode
  output logic [2:0]      seq_code_o,
  output logic            seq_disabled_o,
  output logic            seq_timed_o,
  output logic            seq_reserved_o,
  output logic [6:0]      seq_pct_o,
  // linear regulator
  output logic [4:0]      ldo_vcode_o,
  output logic [11:0]     ldo_mv_o
);
  logic       wr_stb;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic [7:0] rd_data;
  logic [5:0] vset_q;
  logic [4:0] cfg_q;
  logic [7:0] cur_q;
  logic [4:0] ldo_q;
  logic [2:0] seq_q;
  logic       seq_done_q;

  bl_i2c_target u_i2c (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_n_o (sda_oe_n_o),
    .wr_stb_o   (wr_stb),
    .wr_addr_o  (wr_addr),
    .wr_data_o  (wr_data),
    .rd_addr_o  (rd_addr),
    .rd_data_i  (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // writable fields; bits above a field and unmapped addresses are dropped
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      vset_q <= bl_pkg::RST_BUCK_VCODE;
      cfg_q  <= bl_pkg::RST_BUCK_CFG;
      cur_q  <= bl_pkg::RST_BUCK_CUR;
      ldo_q  <= bl_pkg::RST_LDO_VCODE;
    end else if (wr_stb) begin
      case (wr_addr)
        bl_pkg::ADDR_BUCK_VOLT: vset_q <= wr_data[5:0];
        bl_pkg::ADDR_BUCK_CFG:  cfg_q  <= wr_data[4:0];
        bl_pkg::ADDR_BUCK_CUR:  cur_q  <= wr_data;
        bl_pkg::ADDR_LDO_VOLT:  ldo_q  <= wr_data[4:0];
        default: begin
        end
      endcase
    end
  end

  // slot strap caught once after release; the bus can never write it
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      seq_q      <= 3'h0;
      seq_done_q <= 1'b0;
    end else if (!seq_done_q) begin
      seq_q      <= seq_strap_i;
      seq_done_q <= 1'b1;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    case (rd_addr)
      bl_pkg::ADDR_BUCK_VOLT: rd_data = {2'h0, vset_q};
      bl_pkg::ADDR_BUCK_CFG:  rd_data = {seq_q, cfg_q};
      bl_pkg::ADDR_BUCK_CUR:  rd_data = cur_q;
      bl_pkg::ADDR_LDO_VOLT:  rd_data = {3'h0, ldo_q};
      default:                rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // voltage code is latched; changing it under load would step the output
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      buck_vcode_o <= bl_pkg::RST_BUCK_VCODE;
    end else if (!buck_enabled_i) begin
      buck_vcode_o <= vset_q;
    end
  end

  // configuration fields out of flops
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      buck_enable_sel_o <= 2'h0;
      buck_mode_sel_o   <= 2'h0;
      buck_fast_start_o <= 1'b0;
      buck_cmp_fpwm_o   <= 1'b0;
      buck_ind_4u7_o    <= 1'b0;
      buck_hys_off_o    <= 1'b0;
      buck_min_ot_o     <= 1'b0;
      buck_integ_o      <= 1'b0;
    end else begin
      buck_enable_sel_o <= cfg_q[bl_pkg::CFG_EN_LSB +: 2];
      buck_mode_sel_o   <= cfg_q[bl_pkg::CFG_MD_LSB +: 2];
      buck_fast_start_o <= cfg_q[bl_pkg::CFG_FST_BIT];
      buck_cmp_fpwm_o   <= cur_q[bl_pkg::CUR_CMP_BIT];
      buck_ind_4u7_o    <= cur_q[bl_pkg::CUR_IND_BIT];
      buck_hys_off_o    <= cur_q[bl_pkg::CUR_HYS_BIT];
      buck_min_ot_o     <= cur_q[bl_pkg::CUR_MOT_BIT];
      buck_integ_o      <= cur_q[bl_pkg::CUR_INT_BIT];
    end
  end

  // analog scale values, code plus one for current, offset base for voltage
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      buck_ipk_ma_o <= 9'h000;
      ldo_vcode_o   <= 5'h00;
      ldo_mv_o      <= 12'h000;
    end else begin
      buck_ipk_ma_o <= 9'((9'(cur_q[bl_pkg::CUR_IPK_LSB +: 3]) + 9'h001) * bl_pkg::IPK_STEP_MA);
      ldo_vcode_o   <= ldo_q;
      ldo_mv_o      <= 12'(bl_pkg::LDO_BASE_MV + 12'(ldo_q) * bl_pkg::LDO_STEP_MV);
    end
  end

  // slot decode; codes 110 and 111 are pin or enable controlled, not timed
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      seq_code_o     <= 3'h0;
      seq_disabled_o <= 1'b1;
      seq_timed_o    <= 1'b0;
      seq_reserved_o <= 1'b0;
      seq_pct_o      <= bl_pkg::PCT_0;
    end else begin
      seq_code_o     <= seq_q;
      seq_disabled_o <= (seq_q == bl_pkg::SEQ_DISABLED);
      seq_timed_o    <= (seq_q == bl_pkg::SEQ_AT_0) || (seq_q == bl_pkg::SEQ_AT_25) || (seq_q == bl_pkg::SEQ_AT_50);
      seq_reserved_o <= (seq_q == bl_pkg::SEQ_RSV_A) || (seq_q == bl_pkg::SEQ_RSV_B);
      seq_pct_o      <= (seq_q == bl_pkg::SEQ_AT_25) ? bl_pkg::PCT_25 :
                        (seq_q == bl_pkg::SEQ_AT_50) ? bl_pkg::PCT_50 : bl_pkg::PCT_0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_seq_ro;
    @(posedge ref_clk_i) disable iff (!resetn_i) seq_done_q |=> $stable(seq_q);
  endproperty
  a_seq_ro: assert property (p_seq_ro) else $error("slot code changed after capture");

  property p_seq_pct;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      seq_done_q && seq_q == 3'h3 |=> seq_pct_o == 7'h19 && seq_timed_o && !seq_disabled_o;
  endproperty
  a_seq_pct: assert property (p_seq_pct) else $error("slot 011 not decoded as 25 percent");

  property p_ipk;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      resetn_i |=> buck_ipk_ma_o == 9'(($past(cur_q[7:5]) + 9'h001) * 9'h032);
  endproperty
  a_ipk: assert property (p_ipk) else $error("peak current not 50 mA per step");

  property p_ind;
    @(posedge ref_clk_i) disable iff (!resetn_i) $rose(cur_q[3]) |=> buck_ind_4u7_o;
  endproperty
  a_ind: assert property (p_ind) else $error("inductor select not passed out");

  property p_ldo_low;
    @(posedge ref_clk_i) disable iff (!resetn_i) ldo_q == 5'h01 |=> ldo_mv_o == 12'h3e8;
  endproperty
  a_ldo_low: assert property (p_ldo_low) else $error("code 00001 not 1.0 V");

  property p_ldo_top;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (ldo_q == 5'h1f |=> ldo_mv_o == 12'hfa0) and (ldo_q == 5'h10 |=> ldo_mv_o == 12'h9c4);
  endproperty
  a_ldo_top: assert property (p_ldo_top) else $error("code 10000 or 11111 wrong voltage");

  property p_vhold;
    @(posedge ref_clk_i) disable iff (!resetn_i) buck_enabled_i |=> $stable(buck_vcode_o);
  endproperty
  a_vhold: assert property (p_vhold) else $error("voltage code changed while enabled");

  property p_vapply;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      !buck_enabled_i ##1 !buck_enabled_i |-> buck_vcode_o == $past(vset_q);
  endproperty
  a_vapply: assert property (p_vapply) else $error("voltage code not applied while off");

  c_write_vset: cover property (@(posedge ref_clk_i) wr_stb && wr_addr == 8'h07);
  c_read_cfg:   cover property (@(posedge ref_clk_i) rd_addr == 8'h08 && !sda_oe_n_o);
  c_held:       cover property (@(posedge ref_clk_i) buck_enabled_i && vset_q != buck_vcode_o);
endmodule
`default_nettype wire

// *** common/bl_pkg.sv ***
// constants shared by the step-down and linear regulator register bank
package bl_pkg;
  // register byte addresses on the serial bus
  localparam logic [7:0] ADDR_BUCK_VOLT = 8'h07;
  localparam logic [7:0] ADDR_BUCK_CFG  = 8'h08;
  localparam logic [7:0] ADDR_BUCK_CUR  = 8'h09;
  localparam logic [7:0] ADDR_LDO_VOLT  = 8'h0a;
  // reset values
  localparam logic [5:0] RST_BUCK_VCODE = 6'h00;
  localparam logic [4:0] RST_BUCK_CFG   = 5'h00;
  localparam logic [7:0] RST_BUCK_CUR   = 8'h00;
  localparam logic [4:0] RST_LDO_VCODE  = 5'h00;
  // field positions, buck configuration register
  localparam int CFG_SEQ_LSB = 5;
  localparam int CFG_EN_LSB  = 3;
  localparam int CFG_MD_LSB  = 1;
  localparam int CFG_FST_BIT = 0;
  // field positions, buck current register
  localparam int CUR_IPK_LSB = 5;
  localparam int CUR_CMP_BIT = 4;
  localparam int CUR_IND_BIT = 3;
  localparam int CUR_HYS_BIT = 2;
  localparam int CUR_MOT_BIT = 1;
  localparam int CUR_INT_BIT = 0;
  // power-up slot codes
  localparam logic [2:0] SEQ_DISABLED = 3'h0;
  localparam logic [2:0] SEQ_AT_0     = 3'h2;
  localparam logic [2:0] SEQ_AT_25    = 3'h3;
  localparam logic [2:0] SEQ_AT_50    = 3'h4;
  localparam logic [2:0] SEQ_RSV_A    = 3'h1;
  localparam logic [2:0] SEQ_RSV_B    = 3'h5;
  localparam logic [6:0] PCT_0        = 7'h00;
  localparam logic [6:0] PCT_25       = 7'h19;
  localparam logic [6:0] PCT_50       = 7'h32;
  // analog scales in mA and mV
  localparam logic [8:0]  IPK_STEP_MA = 9'h032;
  localparam logic [11:0] LDO_BASE_MV = 12'h384;
  localparam logic [11:0] LDO_STEP_MV = 12'h064;
  // serial bus target address, arbitrary default
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h2a;
endpackage

// *** src/bl_i2c_target.sv ***
// i2c target: address match, register pointer, auto-increment read and write
`timescale 1ns/1ps
`default_nettype none
module bl_i2c_target #(
  parameter logic [6:0] DEV_ADDR = bl_pkg::I2C_TARGET_ADDR
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // bus pins, sda drives low only
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  // register side
  output logic            wr_stb_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic [7:0]      rd_addr_o,
  input  wire logic [7:0] rd_data_i
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_RXACK = 3'b010,
    ST_TX    = 3'b011,
    ST_TXACK = 3'b100
  } bl_i2c_state_type;

  bl_i2c_state_type state_q;
  logic       scl_q, sda_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, ptr_q;
  logic [1:0] phase_q;   // 0 address, 1 pointer, 2 data
  logic       rw_q, drive_q, hack_q;
  logic       rise, fall, start, stop;

  // pins are synchronous, so one sample gives the edges
  always_ff @(posedge ref_clk_i) begin
    scl_q <= resetn_i ? scl_i : 1'b1;
    sda_q <= resetn_i ? sda_i : 1'b1;
  end
  assign rise  = scl_i & ~scl_q;
  assign fall  = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop  = scl_i & scl_q & ~sda_q & sda_i;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine; data changes only while scl is low
  always_ff @(posedge ref_clk_i) begin
    wr_stb_o <= 1'b0;
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      phase_q <= 2'h0;
      rw_q <= 1'b0;
      drive_q <= 1'b0;
      hack_q <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
    end else if (start) begin
      state_q <= ST_RX;
      bit_q <= 4'h0;
      phase_q <= 2'h0;
      drive_q <= 1'b0;
    end else if (stop) begin
      state_q <= ST_IDLE;
      drive_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (rise) begin
            sh_q <= {sh_q[6:0], sda_i};
            bit_q <= bit_q + 4'h1;
          end else if (fall && bit_q == 4'h8) begin
            state_q <= ST_RXACK;
            drive_q <= 1'b1;
            if (phase_q == 2'h0) begin
              rw_q <= sh_q[0];
              if (sh_q[7:1] != DEV_ADDR) begin
                state_q <= ST_IDLE;   // not ours: stay silent until next start
                drive_q <= 1'b0;
              end
            end else if (phase_q == 2'h1) begin
              ptr_q <= sh_q;
            end else begin
              wr_stb_o <= 1'b1;
              wr_addr_o <= ptr_q;
              wr_data_o <= sh_q;
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        ST_RXACK: begin
          if (fall) begin
            bit_q <= 4'h0;
            if (phase_q == 2'h0 && rw_q) begin
              state_q <= ST_TX;
              sh_q <= rd_data_i;
              drive_q <= ~rd_data_i[7];
            end else begin
              state_q <= ST_RX;
              drive_q <= 1'b0;
              phase_q <= (phase_q == 2'h0) ? 2'h1 : 2'h2;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            bit_q <= bit_q + 4'h1;
            sh_q <= {sh_q[6:0], 1'b1};
            drive_q <= (bit_q == 4'h7) ? 1'b0 : ~sh_q[6];
            if (bit_q == 4'h7) begin
              state_q <= ST_TXACK;
            end
          end
        end
        ST_TXACK: begin
          if (rise) begin
            hack_q <= ~sda_i;
          end else if (fall) begin
            bit_q <= 4'h0;
            if (hack_q) begin
              state_q <= ST_TX;
              sh_q <= rd_data_i;
              drive_q <= ~rd_data_i[7];
            end else begin
              state_q <= ST_IDLE;   // host nack ends the read
            end
          end
        end
        default: begin
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // read pointer steps on the host ack rise, so the next byte is ready by the following fall
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rd_addr_o <= 8'h00;
    end else if (state_q == ST_TXACK && rise && !sda_i) begin
      rd_addr_o <= rd_addr_o + 8'h01;
    end else if (state_q != ST_TX && state_q != ST_TXACK) begin
      rd_addr_o <= ptr_q;   // a burst keeps its own pointer until the read ends
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~drive_q;
endmodule
`default_nettype wire

// *** tb/bl_host_model.sv ***
// i2c host model: open-drain bus controller for register writes and reads
`timescale 1ns/1ps
`default_nettype none
module bl_host_model (
  // clock
  input  wire logic ref_clk_i,
  // resolved bus level
  input  wire logic sda_i,
  // host pins, sda enable low pulls the line low
  output logic      scl_o,
  output logic      sda_oe_n_o
);
  initial begin
    scl_o      = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // one bit each way; every scl level lasts 5 clocks, above the 4 the target needs
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_oe_n_o = b;
    wt(3);
    scl_o = 1'b1;
    wt(5);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask
  // start and repeated start: sda falls while scl is high
  task automatic start();
    wt(2);
    sda_oe_n_o = 1'b1;
    wt(3);
    scl_o = 1'b1;
    wt(5);
    sda_oe_n_o = 1'b0;
    wt(5);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_oe_n_o = 1'b0;
    wt(3);
    scl_o = 1'b1;
    wt(5);
    sda_oe_n_o = 1'b1;
    wt(5);
  endtask
  // write one byte; ok is high only when all three bytes were acked
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2;
    start();
    byte_io({dev, 1'b0}, 1'b1, q, k0);
    byte_io(a, 1'b1, q, k1);
    byte_io(d, 1'b1, q, k2);
    stop();
    ok = !k0 && !k1 && !k2;
  endtask
  // pointer write, repeated start, one byte read ended by a nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start();
    byte_io({bl_pkg::I2C_TARGET_ADDR, 1'b0}, 1'b1, q, k);
    byte_io(a, 1'b1, q, k);
    start();
    byte_io({bl_pkg::I2C_TARGET_ADDR, 1'b1}, 1'b1, q, k);
    byte_io(8'hff, 1'b1, d, k);
    stop();
  endtask
  // pointer write, repeated start, two bytes: the first acked, the second ended by a nack
  task automatic rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] q;
    logic       k;
    start();
    byte_io({bl_pkg::I2C_TARGET_ADDR, 1'b0}, 1'b1, q, k);
    byte_io(a, 1'b1, q, k);
    start();
    byte_io({bl_pkg::I2C_TARGET_ADDR, 1'b1}, 1'b1, q, k);
    byte_io(8'hff, 1'b0, d0, k);
    byte_io(8'hff, 1'b1, d1, k);
    stop();
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the step-down and linear regulator register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic [2:0]  seq_strap_i = 3'h0;
  logic        buck_enabled_i = 1'b0;
  logic        sda_o, sda_oe_n_o, host_scl, host_oe_n;
  logic [5:0]  buck_vcode_o;
  logic [1:0]  buck_enable_sel_o, buck_mode_sel_o;
  logic        buck_fast_start_o, buck_cmp_fpwm_o, buck_ind_4u7_o, buck_hys_off_o, buck_min_ot_o, buck_integ_o;
  logic [8:0]  buck_ipk_ma_o;
  logic [2:0]  seq_code_o;
  logic        seq_disabled_o, seq_timed_o, seq_reserved_o;
  logic [6:0]  seq_pct_o;
  logic [4:0]  ldo_vcode_o;
  logic [11:0] ldo_mv_o;
  wire         sda_w = host_oe_n & sda_oe_n_o; // pull-up: high unless someone pulls low
  int          error_cnt = 0;
  int          compares = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  bl_reg_bank dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(host_scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .seq_strap_i(seq_strap_i), .buck_enabled_i(buck_enabled_i),
    .buck_vcode_o(buck_vcode_o), .buck_enable_sel_o(buck_enable_sel_o), .buck_mode_sel_o(buck_mode_sel_o),
    .buck_fast_start_o(buck_fast_start_o), .buck_ipk_ma_o(buck_ipk_ma_o), .buck_cmp_fpwm_o(buck_cmp_fpwm_o),
    .buck_ind_4u7_o(buck_ind_4u7_o), .buck_hys_off_o(buck_hys_off_o), .buck_min_ot_o(buck_min_ot_o),
    .buck_integ_o(buck_integ_o), .seq_code_o(seq_code_o), .seq_disabled_o(seq_disabled_o),
    .seq_timed_o(seq_timed_o), .seq_reserved_o(seq_reserved_o), .seq_pct_o(seq_pct_o),
    .ldo_vcode_o(ldo_vcode_o), .ldo_mv_o(ldo_mv_o));
  bl_host_model host (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(host_scl), .sda_oe_n_o(host_oe_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // reset held 10 clocks; strap is caught at the first edge after release
  task automatic do_reset();
    @(negedge ref_clk_i) resetn_i = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
  endtask
  // expectations from the documented scales
  function automatic logic [6:0] pct(input logic [2:0] c);
    return (c == 3'h3) ? 7'h19 : (c == 3'h4) ? 7'h32 : 7'h00;
  endfunction
  function automatic logic [8:0] ipk(input logic [2:0] c);
    return 9'((c + 1) * 50);
  endfunction
  function automatic logic [11:0] ldo(input logic [4:0] c);
    return 12'(900 + 100 * c);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // watchdog, several times the expected run length
  initial begin
    repeat (80000) @(posedge ref_clk_i);
    error_cnt++;
    print_verdict();
  end
  initial begin
    logic [7:0] d, r;
    logic       ok;
    logic [4:0] lc [6];
    void'($urandom(60274));
    // every strap code through a fresh reset
    for (int c = 0; c < 8; c++) begin
      seq_strap_i = 3'(c);
      do_reset();
      chk("seq_code", 32'(c), 32'(seq_code_o));
      chk("seq_disabled", 32'(c == 0), 32'(seq_disabled_o));
      chk("seq_timed", 32'(c >= 2 && c <= 4), 32'(seq_timed_o));
      chk("seq_reserved", 32'(c == 1 || c == 5), 32'(seq_reserved_o));
      chk("seq_pct", 32'(pct(3'(c))), 32'(seq_pct_o));
    end
    chk("ipk_reset", 32'h32, 32'(buck_ipk_ma_o));
    // slot field ignores writes; writable fields follow the data
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      host.wr(bl_pkg::I2C_TARGET_ADDR, bl_pkg::ADDR_BUCK_CFG, d, ok);
      host.rd(bl_pkg::ADDR_BUCK_CFG, r);
      chk("cfg_read", {24'h0, 3'h7, d[4:0]}, 32'(r));
      chk("cfg_fields", 32'(d[4:0]), 32'({buck_enable_sel_o, buck_mode_sel_o, buck_fast_start_o}));
    end
    // peak current codes, low bits random
    for (int c = 0; c < 8; c++) begin
      d = {3'(c), 5'($urandom())};
      host.wr(bl_pkg::I2C_TARGET_ADDR, bl_pkg::ADDR_BUCK_CUR, d, ok);
      chk("ipk_ma", 32'(ipk(3'(c))), 32'(buck_ipk_ma_o));
      chk("ind_4u7", 32'(d[3]), 32'(buck_ind_4u7_o));
      chk("cur_bits", 32'({d[4], d[2:0]}), 32'({buck_cmp_fpwm_o, buck_hys_off_o, buck_min_ot_o, buck_integ_o}));
      host.rd(bl_pkg::ADDR_BUCK_CUR, r);
      chk("cur_read", 32'(d), 32'(r));
    end
    // linear regulator: end codes, the mid code, then random
    lc = '{5'h00, 5'h01, 5'h10, 5'h1f, 5'($urandom()), 5'($urandom())};
    foreach (lc[i]) begin
      d = {3'($urandom()), lc[i]};
      host.wr(bl_pkg::I2C_TARGET_ADDR, bl_pkg::ADDR_LDO_VOLT, d, ok);
      chk("ldo_code", 32'(lc[i]), 32'(ldo_vcode_o));
      chk("ldo_mv", 32'(ldo(lc[i])), 32'(ldo_mv_o));
      host.rd(bl_pkg::ADDR_LDO_VOLT, r);
      chk("ldo_read", 32'(lc[i]), 32'(r));
    end
    // step-down code held while running, applied once stopped
    buck_enabled_i = 1'b1;
    host.wr(bl_pkg::I2C_TARGET_ADDR, bl_pkg::ADDR_BUCK_VOLT, 8'hff, ok);
    chk("vcode_held", 32'h0, 32'(buck_vcode_o));
    host.rd(bl_pkg::ADDR_BUCK_VOLT, r);
    chk("vcode_read", 32'h3f, 32'(r));
    buck_enabled_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk("vcode_applied", 32'h3f, 32'(buck_vcode_o));
    d = 8'($urandom());
    host.wr(bl_pkg::I2C_TARGET_ADDR, bl_pkg::ADDR_BUCK_VOLT, d, ok);
    chk("vcode_idle", 32'(d[5:0]), 32'(buck_vcode_o));
    // unmapped place is acked, a foreign address is not
    host.wr(bl_pkg::I2C_TARGET_ADDR, 8'h0b, 8'h5a, ok);
    chk("unmapped_ack", 32'h1, 32'(ok));
    host.wr(bl_pkg::I2C_TARGET_ADDR ^ 7'h01, bl_pkg::ADDR_LDO_VOLT, 8'h07, ok);
    chk("foreign_ack", 32'h0, 32'(ok));
    chk("ldo_kept", 32'(lc[5]), 32'(ldo_vcode_o));
    // two-byte read: the pointer steps after the acked byte, the unmapped place reads zero
    host.rd2(bl_pkg::ADDR_LDO_VOLT, r, d);
    chk("burst_first", 32'(lc[5]), 32'(r));
    chk("burst_next", 32'h0, 32'(d));
    chk("sda_o", 32'h0, 32'(sda_o));
    print_verdict();
  end
endmodule
`default_nettype wire
